/* user_glyph_cfg.svh */
// Constants for the user glyph RAM access block.
// Function
// - A write to the glyph port with bit 7 set loads the glyph pointer and leaves the RAM alone.
// - A write with bit 7 clear stores the low seven bits at the pointer and advances it.
// - A read command returns the entry at the pointer with bit 7 zero and advances it.
// - Loads from the first location to the end location are valid; accesses below the end increment.
// - After an access at the end location, glyph data accesses are ignored until a new load.
// - A pointer load in the invalid upper range sets the pointer to the first glyph location.
// - The RAM holds 24 glyphs of five entries; glyph n starts five times n above the first.
`ifndef USER_GLYPH_CFG_SVH
`define USER_GLYPH_CFG_SVH

`define GLYPH_CMD_WRITE     8'h05
`define GLYPH_CMD_READ      8'h85
`define USER_GLYPH_FIRST    8'h80
`define USER_GLYPH_THIRD    8'h8A
`define USER_GLYPH_LAST     8'hF3
`define GLYPH_END_PTR       8'hF7
`define GLYPH_INVALID_MIN   8'hF8
`define GLYPH_CHARS         24
`define GLYPH_COLS          5
`define GLYPH_ENTRIES       120
`define GLYPH_CMD_BITS      5'd8
`define GLYPH_FRAME_BITS    5'd16
`define GLYPH_PTR_BIT       7
`define GLYPH_ENTRY_RESET   7'h00

`endif

/* user_glyph_pkg.sv */
// Types shared by the user glyph RAM access block.
`default_nettype none
package user_glyph_pkg;
	typedef logic [7:0] glyph_ptr_t;
	typedef logic [6:0] glyph_data_t;
	typedef logic [6:0] glyph_idx_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_CMD  = 4'b0010,
		ST_DATA = 4'b0100,
		ST_WAIT = 4'b1000
	} frame_state_e;
endpackage
`default_nettype wire

/* bit_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous level inputs.
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	// Levels
	input  wire logic [WIDTH-1:0] asyncIn,
	input  wire logic [WIDTH-1:0] resetVal,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_r;

	// The reset value is a constant at each instance, so the flops take a constant.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_r  <= '0;
			syncOut <= '0;
		end else begin
			meta_r  <= asyncIn ^ resetVal;
			syncOut <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* user_glyph_ram_access.sv */
// Serial command port, glyph pointer and glyph RAM of the user character store.
`include "user_glyph_cfg.svh"
`default_nettype none
module user_glyph_ram_access
	import user_glyph_pkg::*;
#(
	parameter int ENTRIES = `GLYPH_ENTRIES
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Serial command link
	input  wire logic       csN,
	input  wire logic       sclk,
	input  wire logic       din,
	output logic            dout,
	output logic            doutEn,
	// Display scan read port
	input  wire logic [4:0] scanChar,
	input  wire logic [2:0] scanCol,
	output logic      [6:0] scanData,
	// Status
	output logic      [7:0] glyphPtr,
	output logic            glyphIgnore
);
	// Synchronised link levels; chip select idles high, so it is stored inverted.
	logic [2:0] linkSync;
	logic       csSync;
	logic       sclkSync;
	logic       dinSync;

	bit_sync #(
		.WIDTH(3)
	) u_link_sync (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.asyncIn  ({csN, sclk, din}),
		.resetVal (3'h4),
		.syncOut  (linkSync)
	);

	assign csSync   = linkSync[2] ^ 1'b1;
	assign sclkSync = linkSync[1];
	assign dinSync  = linkSync[0];

	frame_state_e state_r;
	frame_state_e state_nxt;
	logic         sclkPrev_r;
	logic [4:0]   bitCnt_r;
	logic [4:0]   bitCnt_nxt;
	logic [6:0]   shift_r;
	logic [7:0]   cmd_r;
	logic [7:0]   outShift_r;
	logic         dout_r;
	glyph_ptr_t   ptr_r;
	glyph_ptr_t   ptr_nxt;
	logic         ignore_r;
	logic         ignore_nxt;
	glyph_data_t  mem_r [0:ENTRIES-1];
	glyph_data_t  scanData_r;

	// Index of a glyph column, used for the scan port.
	function automatic glyph_idx_t glyphIndex(input logic [4:0] ch, input logic [2:0] col);
		logic [9:0] full;
		full = 10'(ch) * 10'(`GLYPH_COLS) + 10'(col);
		return full[6:0];
	endfunction

	// Index of the RAM entry addressed by a pointer value.
	function automatic glyph_idx_t ptrIndex(input glyph_ptr_t p);
		glyph_ptr_t off;
		off = p - `USER_GLYPH_FIRST;
		return off[6:0];
	endfunction

	// Link edge and frame decoding.
	logic       csLow;
	logic       sclkRise;
	logic       sclkFall;
	logic       inFrame;
	logic       cmdDone;
	logic       frameDone;
	logic [7:0] lastByte;

	assign csLow     = ~csSync;
	assign sclkRise  = sclkSync & ~sclkPrev_r;
	assign sclkFall  = ~sclkSync & sclkPrev_r;
	assign inFrame   = (state_r == ST_CMD) || (state_r == ST_DATA);
	assign lastByte  = {shift_r, dinSync};
	assign cmdDone   = sclkRise && (state_r == ST_CMD) && (bitCnt_r == `GLYPH_CMD_BITS - 5'd1);
	assign frameDone = sclkRise && (state_r == ST_DATA) &&
	                   (bitCnt_r == `GLYPH_FRAME_BITS - 5'd1);

	// Glyph command decoding.
	logic       readStart;
	logic       writeHit;
	logic       writeData;
	logic       ptrLoad;
	logic       dataAccess;
	logic       ptrAtEnd;
	logic       loadInvalid;
	glyph_idx_t memIdx;
	glyph_data_t readEntry;

	assign readStart   = cmdDone && (lastByte == `GLYPH_CMD_READ);
	assign writeHit    = frameDone && (cmd_r == `GLYPH_CMD_WRITE);
	assign ptrLoad     = writeHit && lastByte[`GLYPH_PTR_BIT];
	assign writeData   = writeHit && !lastByte[`GLYPH_PTR_BIT] && !ignore_r;
	assign dataAccess  = writeData || (readStart && !ignore_r);
	assign ptrAtEnd    = (ptr_r == `GLYPH_END_PTR);
	assign loadInvalid = (lastByte >= `GLYPH_INVALID_MIN);
	assign memIdx      = ptrIndex(ptr_r);
	assign readEntry   = ignore_r ? `GLYPH_ENTRY_RESET : mem_r[memIdx];

	always_comb begin
		state_nxt  = state_r;
		bitCnt_nxt = bitCnt_r;
		case (state_r)
			ST_IDLE: begin
				bitCnt_nxt = 5'd0;
				if (csLow) begin
					state_nxt = ST_CMD;
				end
			end
			ST_CMD: begin
				if (sclkRise) begin
					bitCnt_nxt = bitCnt_r + 5'd1;
				end
				if (cmdDone) begin
					state_nxt = ST_DATA;
				end
			end
			ST_DATA: begin
				if (sclkRise) begin
					bitCnt_nxt = bitCnt_r + 5'd1;
				end
				if (frameDone) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				bitCnt_nxt = 5'd0;
			end
			default: begin
				state_nxt  = ST_IDLE;
				bitCnt_nxt = 5'd0;
			end
		endcase
		// A frame cut short by chip select going high is dropped; a read has already acted once its command byte is in.
		if (!csLow) begin
			state_nxt  = ST_IDLE;
			bitCnt_nxt = 5'd0;
		end
	end

	always_comb begin
		ptr_nxt    = ptr_r;
		ignore_nxt = ignore_r;
		if (ptrLoad) begin
			ptr_nxt    = loadInvalid ? `USER_GLYPH_FIRST : lastByte;
			ignore_nxt = 1'b0;
		end else if (dataAccess) begin
			if (ptrAtEnd) begin
				ignore_nxt = 1'b1;
			end else begin
				ptr_nxt = ptr_r + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r    <= ST_IDLE;
			bitCnt_r   <= 5'd0;
			sclkPrev_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			bitCnt_r   <= bitCnt_nxt;
			sclkPrev_r <= sclkSync;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			shift_r <= 7'h00;
			cmd_r   <= 8'h00;
		end else begin
			if (sclkRise && inFrame) begin
				shift_r <= lastByte[6:0];
			end
			if (cmdDone) begin
				cmd_r <= lastByte;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ptr_r    <= `USER_GLYPH_FIRST;
			ignore_r <= 1'b0;
		end else begin
			ptr_r    <= ptr_nxt;
			ignore_r <= ignore_nxt;
		end
	end

	// Read data leaves on falling clock edges so the host samples it on rising ones.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			outShift_r <= 8'h00;
			dout_r     <= 1'b0;
		end else if (readStart) begin
			outShift_r <= {1'b0, readEntry};
		end else if (sclkFall && (state_r == ST_DATA)) begin
			dout_r     <= outShift_r[7];
			outShift_r <= {outShift_r[6:0], 1'b0};
		end else if (!csLow) begin
			outShift_r <= 8'h00;
			dout_r     <= 1'b0;
		end
	end

	// Glyph storage: one flop row per entry, written only at the pointer.
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					mem_r[gi] <= `GLYPH_ENTRY_RESET;
				end else if (writeData && (memIdx == 7'(gi))) begin
					mem_r[gi] <= lastByte[6:0];
				end
			end
		end
	endgenerate

	// Out-of-range scan indices read as blank rather than aliasing another glyph.
	glyph_idx_t scanIdx;
	logic       scanValid;

	assign scanIdx   = glyphIndex(scanChar, scanCol);
	assign scanValid = (scanChar < 5'(`GLYPH_CHARS)) && (scanCol < 3'(`GLYPH_COLS));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			scanData_r <= `GLYPH_ENTRY_RESET;
		end else begin
			scanData_r <= scanValid ? mem_r[scanIdx] : `GLYPH_ENTRY_RESET;
		end
	end

	assign dout        = dout_r;
	assign doutEn      = csLow;
	assign scanData    = scanData_r;
	assign glyphPtr    = ptr_r;
	assign glyphIgnore = ignore_r;
endmodule
`default_nettype wire

/* glyph_host_model.sv */
// Host side of the serial command link, stepped on ref_clk edges.
`default_nettype none
module glyph_host_model (
	// Clock
	input  wire logic ref_clk,
	// Serial command link
	input  wire logic dout,
	output var logic  csN,
	output var logic  sclk,
	output var logic  din
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	// Command byte then data byte, MSB first; read bits are taken late in the high phase.
	task automatic frame(input logic [7:0] cmd, input logic [7:0] data, output logic [7:0] rd);
		logic [15:0] bits;
		bits = {cmd, data};
		rd = 8'h00;
		@(posedge ref_clk) csN <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge ref_clk) din <= bits[i];
			repeat (3) @(posedge ref_clk);
			sclk <= 1'b1;
			repeat (4) @(posedge ref_clk);
			if (i < 8) rd = {rd[6:0], dout};
			sclk <= 1'b0;
		end
		@(posedge ref_clk) csN <= 1'b1;
		// A released data line must not keep showing its last bit.
		din <= ~din;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

/* user_glyph_ram_access_props.sv */
// Port-level checks of the user glyph RAM access block.
`default_nettype none
module user_glyph_ram_access_props #(
	parameter int ENTRIES = 120
) (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       nrst,
	// Link and scan
	input wire logic       csN,
	input wire logic       sclk,
	input wire logic       din,
	input wire logic       dout,
	input wire logic       doutEn,
	input wire logic [4:0] scanChar,
	input wire logic [2:0] scanCol,
	input wire logic [6:0] scanData,
	// Status
	input wire logic [7:0] glyphPtr,
	input wire logic       glyphIgnore
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_ptr_range; glyphPtr >= 8'h80 && glyphPtr <= 8'hF7; endproperty
	a_ptr_range: assert property (p_ptr_range) else $error("pointer left range");
	property p_ign_end; glyphIgnore |-> glyphPtr == 8'hF7; endproperty
	a_ign_end: assert property (p_ign_end) else $error("ignore off end");
	property p_ign_rise; $rose(glyphIgnore) |-> $past(glyphPtr) == 8'hF7; endproperty
	a_ign_rise: assert property (p_ign_rise) else $error("ignore set early");
	property p_ign_hold; glyphIgnore ##1 glyphIgnore |-> $stable(glyphPtr); endproperty
	a_ign_hold: assert property (p_ign_hold) else $error("pointer moved while ignoring");
	// Pointer updates land a few clocks after an sclk rise, so a long low phase is quiet.
	property p_quiet; !sclk [*8] |-> $stable(glyphPtr); endproperty
	a_quiet: assert property (p_quiet) else $error("pointer moved without link");
	property p_cs_idle; csN [*4] |-> !doutEn && !dout; endproperty
	a_cs_idle: assert property (p_cs_idle) else $error("output driven outside frame");
	property p_cs_act; !csN [*4] |-> doutEn; endproperty
	a_cs_act: assert property (p_cs_act) else $error("output not driven in frame");
	property p_scan_oor; scanChar > 5'd23 || scanCol > 3'd4 |=> scanData == 7'h00; endproperty
	a_scan_oor: assert property (p_scan_oor) else $error("scan data off map");
	cover property ($rose(glyphIgnore));
	cover property ($fell(glyphIgnore));
	cover property (csN ##1 !csN);
endmodule
bind user_glyph_ram_access user_glyph_ram_access_props #(.ENTRIES(ENTRIES)) u_props (
	.ref_clk(ref_clk), .nrst(nrst), .csN(csN), .sclk(sclk), .din(din), .dout(dout),
	.doutEn(doutEn), .scanChar(scanChar), .scanCol(scanCol), .scanData(scanData),
	.glyphPtr(glyphPtr), .glyphIgnore(glyphIgnore));
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the user glyph RAM access block.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] c, d, p; logic g; logic [7:0] r;} row_s;
	logic       ref_clk = 1'b0;
	logic       nrst = 1'b0;
	logic       csN, sclk, din, dout, doutEn, glyphIgnore;
	logic [4:0] scanChar = 5'h00;
	logic [2:0] scanCol = 3'h0;
	logic [6:0] scanData;
	logic [7:0] glyphPtr, rd;
	int         n_errors = 0;
	int         tests_run = 0;
	logic [6:0] colExp [7] = '{7'h42, 7'h61, 7'h51, 7'h49, 7'h46, 7'h33, 7'h11};
	row_s       rows [19] = '{
		{8'h05, 8'h8A, 8'h8A, 1'b0, 8'h00}, {8'h05, 8'h42, 8'h8B, 1'b0, 8'h00},
		{8'h05, 8'h61, 8'h8C, 1'b0, 8'h00}, {8'h05, 8'h51, 8'h8D, 1'b0, 8'h00},
		{8'h05, 8'h49, 8'h8E, 1'b0, 8'h00}, {8'h05, 8'h46, 8'h8F, 1'b0, 8'h00},
		{8'h05, 8'h8A, 8'h8A, 1'b0, 8'h00}, {8'h85, 8'h00, 8'h8B, 1'b0, 8'h42},
		{8'h85, 8'h00, 8'h8C, 1'b0, 8'h61}, {8'h05, 8'hFB, 8'h80, 1'b0, 8'h00},
		{8'h05, 8'hF6, 8'hF6, 1'b0, 8'h00}, {8'h05, 8'h33, 8'hF7, 1'b0, 8'h00},
		{8'h05, 8'h11, 8'hF7, 1'b1, 8'h00}, {8'h85, 8'h00, 8'hF7, 1'b1, 8'h00},
		{8'h05, 8'hF3, 8'hF3, 1'b0, 8'h00}, {8'h33, 8'h8A, 8'hF3, 1'b0, 8'h00},
		{8'h85, 8'h00, 8'hF4, 1'b0, 8'h00}, {8'h05, 8'hF7, 8'hF7, 1'b0, 8'h00},
		{8'h85, 8'h00, 8'hF7, 1'b1, 8'h11}};
	always #4 ref_clk = ~ref_clk;
	glyph_host_model u_glyph_host_model (.ref_clk(ref_clk), .dout(dout), .csN(csN),
		.sclk(sclk), .din(din));
	user_glyph_ram_access u_user_glyph_ram_access (.ref_clk(ref_clk), .nrst(nrst),
		.csN(csN), .sclk(sclk), .din(din), .dout(dout), .doutEn(doutEn),
		.scanChar(scanChar), .scanCol(scanCol), .scanData(scanData),
		.glyphPtr(glyphPtr), .glyphIgnore(glyphIgnore));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (n_errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		check(glyphPtr, 8'h80);
		foreach (rows[i]) begin
			u_glyph_host_model.frame(rows[i].c, rows[i].d, rd);
			check(glyphPtr, rows[i].p);
			check({7'h00, glyphIgnore}, {7'h00, rows[i].g});
			if (rows[i].c == 8'h85) check(rd, rows[i].r);
		end
		for (int k = 0; k < 7; k++) begin
			scanChar <= (k < 5) ? 5'd2 : 5'd23;
			scanCol <= (k < 5) ? k[2:0] : k[2:0] - 3'd2;
			repeat (2) @(posedge ref_clk);
			check({1'b0, scanData}, {1'b0, colExp[k]});
		end
		scanChar <= 5'd24;
		repeat (2) @(posedge ref_clk);
		check({1'b0, scanData}, 8'h00);
		scanChar <= 5'd23;
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(glyphPtr, 8'h80);
		check({1'b0, scanData}, 8'h00);
		nrst <= 1'b1;
		u_glyph_host_model.frame(8'h05, 8'h55, rd);
		scanChar <= 5'd0;
		scanCol <= 3'd0;
		repeat (2) @(posedge ref_clk);
		check(glyphPtr, 8'h81);
		check({1'b0, scanData}, 8'h55);
		results();
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		results();
	end
endmodule
`default_nettype wire
